/* src/lwss_defines.svh */
/*
  Constants of the late-write synchronous SRAM core: array shape, byte
  lanes, protocol pin codes and the offsets and fields of the APB registers.
  Assumes inclusion by its bare name before any design file that uses it.
*/
`ifndef LWSS_DEFINES_SVH
`define LWSS_DEFINES_SVH

// ----------------------------------------------------------------
// Array shape
// ----------------------------------------------------------------
`define LWSS_WORDS 131072
`define LWSS_AW 17
`define LWSS_DW 36
`define LWSS_LANES 4
`define LWSS_LANE_W 9
`define LWSS_NO_LANES 4'hF
`define LWSS_BUF_DEPTH 2

// ----------------------------------------------------------------
// Protocol pin codes {pin one, pin two}
// ----------------------------------------------------------------
`define LWSS_PINS_REG 2'h1
`define LWSS_PINS_FT 2'h0
`define LWSS_PINS_LAT 2'h2
`define LWSS_PINS_DC 2'h3

// ----------------------------------------------------------------
// APB registers
// ----------------------------------------------------------------
`define LWSS_PAW 12
`define LWSS_OFF_CTRL 12'h000
`define LWSS_OFF_STATUS 12'h004
`define LWSS_OFF_WCOUNT 12'h008
`define LWSS_CTRL_HOLD 0
`define LWSS_ST_PROTO_LO 0
`define LWSS_ST_BUFV 2
`define LWSS_ST_FULL 3
`define LWSS_ST_SLEEP 4
`define LWSS_ST_OVF 5

`endif

/* src/lwss_pkg.sv */
/*
  Types of the late-write synchronous SRAM core.
  Assumes nothing of its surroundings.
*/
package lwss_pkg;

  // ----------------------------------------------------------------
  // Read protocols
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LWSS_REG,
    LWSS_FT,
    LWSS_LAT,
    LWSS_DC
  } lwss_proto_t;

endpackage

/* src/lwss_fifo2.sv */
/*
  Small valid/ready buffer for committed writes.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module lwss_fifo2 #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];

  always_comb begin
    cnt_d = cnt_q + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      in_ready <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      in_ready <= (cnt_d < CW'(DEPTH));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

endmodule

`default_nettype wire

/* src/lwss_core.sv */
/*
  Late-write synchronous SRAM core with four read protocols, byte lanes,
  a one-entry late-write buffer and an APB register port.
  Assumes all pins synchronous to pclk; the data pin is split into input,
  output and enable, and the wire is resolved outside.
*/
// What this block does
// RL1 - Array of 131072 words, 36 bits
// RL2 - Synchronous inputs sampled on rising clock edge
// RL3 - Four read protocols, chosen by pins only
// RL4 - Pin codes select the four protocols
// RL5 - Protocol pins fixed from power-up onward
// RL6 - Registered protocol: data in cycle n+1
// RL7 - Latched and flow-through: data in cycle n
// RL8 - Dual-clock: output register timed by timer
// RL9 - Write data follows locator one cycle later
// RL10 - New write commits buffered write, reloads buffer
// RL11 - Write strobe floats outputs in FT, latched
// RL12 - Array write timing generated internally
// RL13 - Sleep floats outputs this and next cycle
// RL14 - Four 9-bit lanes, each own strobe
// RL15 - All strobes low writes all 36 bits
// RL16 - Only lanes with low strobe update
// RL17 - No strobe low aborts; registered floats next
// RL18 - Deselect performs no access, outputs float
// RL19 - Read data driven only with enable low
`timescale 1ns/1ps
`default_nettype none
`include "lwss_defines.svh"

module lwss_core #(
  parameter int WORDS = `LWSS_WORDS,
  parameter int BUF_DEPTH = `LWSS_BUF_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`LWSS_PAW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [`LWSS_AW-1:0] word_locator_in,
  input wire logic sync_select_n,
  input wire logic global_write_strobe_n,
  input wire logic [`LWSS_LANES-1:0] byte_write_strobe_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic protocol_pin_one,
  input wire logic protocol_pin_two,
  input wire logic output_drive_timer,
  input wire logic [`LWSS_DW-1:0] dq_in,
  output logic [`LWSS_DW-1:0] dq_out,
  output logic dq_oe,
  output logic commit_ready
);

  localparam int AW = `LWSS_AW;
  localparam int DW = `LWSS_DW;
  localparam int LN = `LWSS_LANES;
  localparam int LW = `LWSS_LANE_W;
  localparam int CMW = AW + LN + DW;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [DW-1:0] mem_q [WORDS];
  lwss_pkg::lwss_proto_t proto_q;
  lwss_pkg::lwss_proto_t proto_d;
  logic cap_q;
  logic sleep_q;
  logic sel;
  logic rd;
  logic wr_req;
  logic wr;
  logic abort;
  logic wr_ok;
  logic buf_vld_q;
  logic pend_q;
  logic [AW-1:0] buf_addr_q;
  logic [LN-1:0] buf_be_q;
  logic [DW-1:0] buf_data_q;
  logic [DW-1:0] buf_fwd;
  logic [DW-1:0] rd_word;
  logic [DW-1:0] rdp_data_q;
  logic rdp_v_q;
  logic fifo_in_valid;
  logic fifo_push;
  logic [CMW-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [CMW-1:0] fifo_out_data;
  logic [AW-1:0] fo_addr;
  logic [LN-1:0] fo_be;
  logic [DW-1:0] fo_data;
  logic hold_q;
  logic ovf_q;
  logic [31:0] wcount_q;
  logic [31:0] rdmux;
  logic mapped;
  logic apb_wr;

  // ----------------------------------------------------------------
  // Protocol capture after reset release
  // ----------------------------------------------------------------
  always_comb begin
    unique case ({protocol_pin_one, protocol_pin_two})
      `LWSS_PINS_REG: proto_d = lwss_pkg::LWSS_REG;
      `LWSS_PINS_FT: proto_d = lwss_pkg::LWSS_FT;
      `LWSS_PINS_LAT: proto_d = lwss_pkg::LWSS_LAT;
      `LWSS_PINS_DC: proto_d = lwss_pkg::LWSS_DC;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proto_q <= lwss_pkg::LWSS_REG;
      cap_q <= 1'b0;
    end else if (!cap_q) begin
      proto_q <= proto_d; // RL3 RL4 RL5
      cap_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Cycle decode
  // ----------------------------------------------------------------
  assign sel = cap_q & ~sync_select_n & ~sleep_request; // RL2 RL18 RL13
  assign rd = sel & global_write_strobe_n;
  assign wr_req = sel & ~global_write_strobe_n;
  assign abort = wr_req & (byte_write_strobe_n == `LWSS_NO_LANES); // RL17
  assign wr = wr_req & ~abort;
  assign wr_ok = wr & (~buf_vld_q | commit_ready);
  assign buf_fwd = pend_q ? dq_in : buf_data_q; // RL9

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_request;
    end
  end

  // ----------------------------------------------------------------
  // Late-write buffer
  // ----------------------------------------------------------------
  assign fifo_in_valid = wr & buf_vld_q; // RL10
  assign fifo_push = fifo_in_valid & commit_ready;
  assign fifo_in_data = {buf_addr_q, buf_be_q, buf_fwd};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_vld_q <= 1'b0;
      pend_q <= 1'b0;
      buf_addr_q <= '0;
      buf_be_q <= '0;
    end else begin
      pend_q <= wr_ok;
      if (wr_ok) begin
        buf_vld_q <= 1'b1; // RL10
        buf_addr_q <= word_locator_in;
        buf_be_q <= ~byte_write_strobe_n; // RL14 RL15 RL16
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_data_q <= '0;
    end else if (pend_q) begin
      buf_data_q <= dq_in; // RL9 RL15
    end
  end

  lwss_fifo2 #(
    .W(CMW),
    .DEPTH(BUF_DEPTH)
  ) u_commit (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(fifo_in_valid),
    .in_ready(commit_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(~hold_q),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------
  assign fifo_pop = fifo_out_valid & ~hold_q;
  assign fo_addr = fifo_out_data[CMW-1 -: AW];
  assign fo_be = fifo_out_data[DW+LN-1 -: LN];
  assign fo_data = fifo_out_data[DW-1:0];

  always_ff @(posedge pclk) begin
    if (fifo_pop) begin
      for (int i = 0; i < LN; i++) begin
        if (fo_be[i]) begin
          mem_q[fo_addr][i*LW +: LW] <= fo_data[i*LW +: LW]; // RL1 RL12 RL16
        end
      end
    end
  end

  // Read with forwarding of the buffered write
  always_comb begin
    rd_word = mem_q[word_locator_in];
    if (buf_vld_q && (buf_addr_q == word_locator_in)) begin
      for (int i = 0; i < LN; i++) begin
        if (buf_be_q[i]) begin
          rd_word[i*LW +: LW] = buf_fwd[i*LW +: LW];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output path
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdp_v_q <= 1'b0;
      rdp_data_q <= '0;
    end else begin
      rdp_v_q <= rd; // RL6 RL17 RL18
      if (rd) begin
        rdp_data_q <= rd_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_out <= '0;
    end else begin
      unique case (proto_q)
        lwss_pkg::LWSS_REG: dq_out <= rdp_data_q; // RL6
        lwss_pkg::LWSS_FT: dq_out <= rd ? rd_word : '0; // RL7
        lwss_pkg::LWSS_LAT: begin
          if (rd) begin
            dq_out <= rd_word; // RL7
          end
        end
        lwss_pkg::LWSS_DC: begin
          if (rd && output_drive_timer) begin
            dq_out <= rd_word; // RL8
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_oe <= 1'b0;
    end else if (output_enable_n || sleep_request || sleep_q) begin
      dq_oe <= 1'b0; // RL13 RL19
    end else if (proto_q == lwss_pkg::LWSS_REG) begin
      dq_oe <= rdp_v_q; // RL6 RL17
    end else if (proto_q == lwss_pkg::LWSS_DC) begin
      dq_oe <= rd & (output_drive_timer | dq_oe); // RL8
    end else begin
      dq_oe <= rd; // RL7 RL11 RL18
    end
  end

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  assign mapped = (paddr == `LWSS_OFF_CTRL) ||
                  (paddr == `LWSS_OFF_STATUS) ||
                  (paddr == `LWSS_OFF_WCOUNT);
  assign apb_wr = psel & penable & pwrite & pready;

  always_comb begin
    rdmux = '0;
    unique case (paddr)
      `LWSS_OFF_CTRL: rdmux[`LWSS_CTRL_HOLD] = hold_q;
      `LWSS_OFF_STATUS: begin
        rdmux[`LWSS_ST_PROTO_LO +: 2] = proto_q;
        rdmux[`LWSS_ST_BUFV] = buf_vld_q;
        rdmux[`LWSS_ST_FULL] = ~commit_ready;
        rdmux[`LWSS_ST_SLEEP] = sleep_q;
        rdmux[`LWSS_ST_OVF] = ovf_q;
      end
      `LWSS_OFF_WCOUNT: rdmux = wcount_q;
      default: rdmux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0 : rdmux;
        pslverr <= ~mapped;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 1'b0;
    end else if (apb_wr && (paddr == `LWSS_OFF_CTRL)) begin
      hold_q <= pwdata[`LWSS_CTRL_HOLD];
    end
  end

  // Overflow: a write refused because the commit buffer is full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_q <= 1'b0;
    end else if (fifo_in_valid && !commit_ready) begin
      ovf_q <= 1'b1;
    end else if (apb_wr && (paddr == `LWSS_OFF_STATUS) &&
                 pwdata[`LWSS_ST_OVF]) begin
      ovf_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcount_q <= '0;
    end else if (fifo_pop) begin
      wcount_q <= wcount_q + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rr_lat;
    (proto_q == lwss_pkg::LWSS_REG && rd) ##1
      (!output_enable_n && !sleep_request && !sleep_q)
      |=> dq_oe && (dq_out == $past(rd_word, 2));
  endproperty
  a_rr_lat: assert property (p_rr_lat) else $error("registered read late"); // RL6

  property p_ft_lat;
    ((proto_q == lwss_pkg::LWSS_FT || proto_q == lwss_pkg::LWSS_LAT) &&
      rd && !output_enable_n && !sleep_q)
      |=> dq_oe && (dq_out == $past(rd_word));
  endproperty
  a_ft_lat: assert property (p_ft_lat) else $error("same-cycle read wrong"); // RL7

  property p_dc;
    (proto_q == lwss_pkg::LWSS_DC && rd && output_drive_timer &&
      !output_enable_n && !sleep_q) |=> dq_oe && (dq_out == $past(rd_word));
  endproperty
  a_dc: assert property (p_dc) else $error("dual-clock read wrong"); // RL8

  property p_wr_float;
    ((proto_q == lwss_pkg::LWSS_FT || proto_q == lwss_pkg::LWSS_LAT) &&
      wr_req) |=> !dq_oe;
  endproperty
  a_wr_float: assert property (p_wr_float) else $error("write not floated"); // RL11

  property p_sleep;
    sleep_request |=> !dq_oe ##1 !dq_oe;
  endproperty
  a_sleep: assert property (p_sleep) else $error("driven in sleep"); // RL13

  property p_oe_gate;
    output_enable_n |=> !dq_oe;
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("driven with oe high"); // RL19

  property p_desel_rr;
    (proto_q == lwss_pkg::LWSS_REG && sync_select_n) |-> ##2 !dq_oe;
  endproperty
  a_desel_rr: assert property (p_desel_rr) else $error("deselect drove"); // RL18

  property p_abort;
    abort |-> !fifo_push ##1 ($stable(buf_addr_q) && $stable(buf_be_q));
  endproperty
  a_abort: assert property (p_abort) else $error("abort changed buffer"); // RL17

  property p_commit;
    (wr_ok && buf_vld_q) |-> fifo_push &&
      (fifo_in_data[CMW-1 -: AW] == buf_addr_q);
  endproperty
  a_commit: assert property (p_commit) else $error("buffer not committed"); // RL10

  property p_late_data;
    wr_ok |=> (buf_be_q == ~$past(byte_write_strobe_n)) ##1
      (buf_data_q == $past(dq_in));
  endproperty
  a_late_data: assert property (p_late_data) else $error("late data lost"); // RL15

  c_rr_read: cover property (proto_q == lwss_pkg::LWSS_REG && rd ##1 dq_oe);
  c_b2b_wr: cover property (wr_ok ##1 wr_ok);
  c_full: cover property (fifo_in_valid && !commit_ready);
  c_abort: cover property (abort);

endmodule

`default_nettype wire

/* tb/lwss_ctl_model.sv */
/*
  Memory controller model: drives locator, selects, strobes and late data.
  Assumes the core samples every pin on the rising pclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lwss_defines.svh"

module lwss_ctl_model (
  input wire logic pclk,
  output logic [`LWSS_AW-1:0] word_locator_in,
  output logic sync_select_n,
  output logic global_write_strobe_n,
  output logic [`LWSS_LANES-1:0] byte_write_strobe_n,
  input wire logic dq_oe,
  input wire logic [`LWSS_DW-1:0] dq_out,
  output logic [`LWSS_DW-1:0] dq_in
);
  logic [`LWSS_DW-1:0] staged_q;
  logic [`LWSS_DW-1:0] data_q;
  logic drive_q;

  initial begin
    word_locator_in = '0;
    sync_select_n = 1'b1;
    global_write_strobe_n = 1'b1;
    byte_write_strobe_n = 4'hF;
    staged_q = '0;
    data_q = '0;
    drive_q = 1'b0;
  end

  // ----------------------------------------------------------------
  // Late data
  // ----------------------------------------------------------------
  // Data one edge behind its write controls
  always @(posedge pclk) begin
    drive_q <= !sync_select_n && !global_write_strobe_n;
    data_q <= staged_q;
  end

  // Released line shows inverse of last data
  assign dq_in = dq_oe ? dq_out : (drive_q ? data_q : ~data_q);

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  // Strobes only, no pulse shaping
  task automatic issue(input logic [16:0] a, input logic sel_n,
                       input logic wr_n, input logic [3:0] bw_n,
                       input logic [35:0] d);
    @(posedge pclk);
    word_locator_in <= a;
    sync_select_n <= sel_n;
    global_write_strobe_n <= wr_n;
    byte_write_strobe_n <= bw_n;
    staged_q <= d;
  endtask
endmodule

`default_nettype wire

/* tb/tb.sv */
/*
  Self-checking bench of the SRAM core over all four read protocols.
  Assumes the controller model and the core sources are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lwss_defines.svh"

module tb;
  localparam logic [1:0] PIN_TAB [4] = '{`LWSS_PINS_REG, `LWSS_PINS_FT,
                                         `LWSS_PINS_LAT, `LWSS_PINS_DC};
  localparam logic [16:0] A0 = 17'h00010;
  localparam logic [16:0] A1 = 17'h1FFFF;
  localparam logic [16:0] A2 = 17'h00000;
  localparam logic [16:0] A3 = 17'h00100;
  localparam logic [35:0] D0 = 36'h123456789;
  localparam logic [35:0] D1 = 36'h9ABCDEF01;
  localparam logic [35:0] D2 = 36'h5A5A5A5A5;
  localparam logic [35:0] DF = 36'hFFFFFFFFF;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic pready, pslverr, dq_oe, commit_ready;
  logic [31:0] prdata;
  logic [16:0] word_locator_in;
  logic sync_select_n, global_write_strobe_n;
  logic [3:0] byte_write_strobe_n;
  logic output_enable_n = 1'b0;
  logic sleep_request = 1'b0;
  logic protocol_pin_one = 1'b0;
  logic protocol_pin_two = 1'b1;
  logic output_drive_timer = 1'b1;
  logic [35:0] dq_in, dq_out;
  logic [31:0] r;
  logic e;
  int n_mismatch = 0;
  int checks_done = 0;
  lwss_pkg::lwss_proto_t proto;

  always #2 pclk = ~pclk;

  lwss_core #(.WORDS(`LWSS_WORDS), .BUF_DEPTH(`LWSS_BUF_DEPTH)) i_lwss_core (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
    .prdata, .pslverr, .word_locator_in, .sync_select_n,
    .global_write_strobe_n, .byte_write_strobe_n, .output_enable_n,
    .sleep_request, .protocol_pin_one, .protocol_pin_two,
    .output_drive_timer, .dq_in, .dq_out, .dq_oe, .commit_ready);

  lwss_ctl_model i_lwss_ctl_model (
    .pclk, .word_locator_in, .sync_select_n, .global_write_strobe_n,
    .byte_write_strobe_n, .dq_oe, .dq_out, .dq_in);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_pin(input string what, input logic [35:0] exp,
                         input logic [35:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_reg(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic op(input logic [16:0] a, input logic sel_n,
                    input logic wr_n, input logic [3:0] bw_n,
                    input logic [35:0] d);
    i_lwss_ctl_model.issue(a, sel_n, wr_n, bw_n, d);
  endtask

  task automatic rd_chk(input logic [16:0] a, input logic [35:0] exp,
                        input logic drv);
    op(a, 1'b0, 1'b1, 4'hF, '0);
    op(a, 1'b1, 1'b1, 4'hF, '0);
    if (proto == lwss_pkg::LWSS_REG)
      @(posedge pclk);
    #1;
    chk_pin("dq_oe", {35'h0, drv}, {35'h0, dq_oe});
    if (drv)
      chk_pin("dq_out", exp, dq_out);
    @(posedge pclk);
    #1;
    chk_pin("dq_oe idle", '0, {35'h0, dq_oe});
  endtask

  function automatic logic [35:0] merge(input logic [35:0] old,
      input logic [35:0] nw, input logic [3:0] bw_n);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (!bw_n[i])
        merge[9*i+:9] = nw[9*i+:9];
  endfunction

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    for (int p = 0; p < 4; p++) begin
      proto = lwss_pkg::lwss_proto_t'(p);
      @(posedge pclk);
      presetn <= 1'b0;
      {protocol_pin_one, protocol_pin_two} <= PIN_TAB[p];
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(`LWSS_OFF_STATUS, 1'b0, '0);
      chk_reg("protocol", 32'(p), r & 32'h3);
      op(A0, 1'b0, 1'b0, 4'h0, D0);
      op(A1, 1'b0, 1'b0, 4'h0, D1);
      op(A1, 1'b0, 1'b0, 4'hA, DF);
      op(A0, 1'b0, 1'b0, 4'hF, '0);
      rd_chk(A0, D0, 1'b1);
      rd_chk(A1, merge(D1, DF, 4'hA), 1'b1);
      output_enable_n <= 1'b1;
      rd_chk(A0, D0, 1'b0);
      output_enable_n <= 1'b0;
      // Read, write, read; registered output needs one dead cycle
      op(A0, 1'b0, 1'b1, 4'hF, '0);
      if (proto == lwss_pkg::LWSS_REG) begin
        op(A0, 1'b1, 1'b1, 4'hF, '0);
        @(posedge pclk);
      end else begin
        op(A2, 1'b0, 1'b0, 4'h0, D2);
      end
      #1;
      chk_pin("rw data", D0, dq_out);
      if (proto == lwss_pkg::LWSS_REG)
        op(A2, 1'b0, 1'b0, 4'h0, D2);
      op(A2, 1'b1, 1'b1, 4'hF, '0);
      #1;
      chk_pin("rw dq_oe", '0, {35'h0, dq_oe});
      rd_chk(A2, D2, 1'b1);
      sleep_request <= 1'b1;
      op(A0, 1'b0, 1'b1, 4'hF, '0);
      op(A0, 1'b1, 1'b1, 4'hF, '0);
      #1;
      chk_pin("sleep n", '0, {35'h0, dq_oe});
      @(posedge pclk);
      #1;
      chk_pin("sleep n+1", '0, {35'h0, dq_oe});
      sleep_request <= 1'b0;
      if (proto == lwss_pkg::LWSS_DC) begin
        output_drive_timer <= 1'b0;
        op(A0, 1'b0, 1'b1, 4'hF, '0);
        op(A0, 1'b1, 1'b1, 4'hF, '0);
        #1;
        chk_pin("timer low", '0, {35'h0, dq_oe});
        output_drive_timer <= 1'b1;
      end
      repeat (4) @(posedge pclk);
      apb(`LWSS_OFF_WCOUNT, 1'b0, '0);
      chk_reg("wcount", 32'h3, r);
      if (p == 0) begin
        apb(`LWSS_OFF_CTRL, 1'b1, 32'h1);
        apb(`LWSS_OFF_CTRL, 1'b0, '0);
        chk_reg("ctrl", 32'h1, r);
        for (int i = 0; i < 4; i++)
          op(A3 + 17'(i), 1'b0, 1'b0, 4'h0, D1);
        op(A3, 1'b1, 1'b1, 4'hF, '0);
        #1;
        chk_pin("commit_ready full", '0, {35'h0, commit_ready});
        apb(`LWSS_OFF_STATUS, 1'b0, '0);
        chk_reg("status full", 32'h2C, r);
        apb(`LWSS_OFF_CTRL, 1'b1, '0);
        repeat (4) @(posedge pclk);
        #1;
        chk_pin("commit_ready", 36'h1, {35'h0, commit_ready});
        apb(`LWSS_OFF_STATUS, 1'b1, 32'h20);
        apb(`LWSS_OFF_STATUS, 1'b0, '0);
        chk_reg("status clear", 32'h04, r);
        apb(12'h00C, 1'b0, '0);
        chk_reg("unmapped err", 32'h1, {31'h0, e});
        chk_reg("unmapped data", '0, r);
        apb(`LWSS_OFF_WCOUNT, 1'b0, '0);
        chk_reg("wcount drained", 32'h5, r);
      end
    end
    tally_and_finish();
  end

  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
